// ==== acc_consts.svh ====
// Constants of the converter control block: CRC, timing, field codes.
// Assumes inclusion by bare name from the package and the design.
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
// =====================================================
// CRC on the serial link
`define ACC_CRC_POLY 8'h07
`define ACC_CRC_SEED 8'h00
// =====================================================
// Timing
`define ACC_CLK_MHZ 100
`define ACC_CAL_TIME_NS 1000
`define ACC_CAL_CYC ((`ACC_CAL_TIME_NS*`ACC_CLK_MHZ+999)/1000)
// =====================================================
// Field codes and positions
`define ACC_APP_CHID 2'b01
`define ACC_APP_STAT 2'b10
`define ACC_FRAC_BITS 4
`define ACC_RX_LAST 3'h7
`define ACC_ALL_ANALOG 8'hff
`endif

// ==== acc_pkg.sv ====
// Types shared by the converter control block.
// Assumes acc_consts.svh on the include path.
`include "acc_consts.svh"
package acc_pkg;
  // =====================================================
  // Conversion sequencer states
  typedef enum logic [0:0] {
    ACC_S_IDLE = 1'b0,
    ACC_S_WAIT = 1'b1
  } acc_state_t;
  // =====================================================
  // Per-channel pin configuration, bit n belongs to channel n
  typedef struct packed {
    logic [7:0] func;
    logic [7:0] dir;
    logic [7:0] drv;
    logic [7:0] lvl;
  } acc_pin_cfg_t;
  // =====================================================
  // Finished conversion word and its channel
  typedef struct packed {
    logic [15:0] data;
    logic [2:0] chan;
  } acc_result_t;
endpackage

// ==== acc_ctrl.sv ====
// Control logic of an eight-channel 12-bit sampling converter.
// Assumes a converter core on clk and a host link on its own sclk.
//
// Operation
// - Reset leaves all eight channels as analog inputs.
// - Function, direction and driver bits pick analog, input or output.
// - Readback shows the real level of every digital channel.
// - Push-pull outputs drive the last written output level bit; open-drain ones drive only a 0.
// - Results are straight binary, 000 low to FFF full scale.
// - Setting the calibration bit starts an offset calibration.
// - The calibration bit falls to 0 when calibration ends.
// - One 3-bit averaging factor serves every analog channel.
// - Averaging gives a 16-bit result, LSB equals reference over 2^16.
// - Host starts the first conversion; the rest run internally. Autonomous mode here starts on its own, without conv_trigger.
// - Autonomous mode averages enabled analog channels in turn.
// - Window compare uses the top 12 bits of the average.
// - With CRC on, each sent byte is followed by its CRC.
// - CRC polynomial x^8+x^2+x+1; every incoming byte is checked.
// - CRC generation and checking work only while CRC is enabled.
// - A CRC mismatch discards the data and sets the fault flag.
// - Fault flag blocks writes; host clears it by writing 1.
// - With alert on fault set, a CRC error raises the alert.
// - Append selection 10b appends fault, window and calibration bits plus a 0 to results.
// - Autonomous mode with halt on fault stops after a CRC error.
// - Results go MSB first, 16 bits averaged, else 12 plus 4.
`timescale 1ns/100ps
`include "acc_consts.svh"
module acc_ctrl #(
  parameter int CAL_CYC = `ACC_CAL_CYC
)(
  input logic clk, // System clock
  input logic rst_n, // Async reset, active low
  input logic ce, // Clock enable for the clk domain
  input logic sclk, // Link clock from host
  input logic cs_n, // Link frame select, active low
  input logic sdi, // Link data in
  output logic sdo, // Link data out
  output logic sdo_oe, // Link data out enable
  input acc_pkg::acc_pin_cfg_t pin_cfg, // Channel configuration
  input logic [7:0] gpio_in, // Pin levels
  output logic [7:0] gpio_out, // Pin drive level
  output logic [7:0] gpio_oe, // Pin drive enable
  output logic [7:0] analog_sel, // Channels set to analog function
  output logic [7:0] pin_level_readback, // Digital pin levels
  input logic cal_start, // Pulse: set calibration bit
  output logic cal_busy, // Calibration bit
  input logic [2:0] average_factor, // Averaging factor
  input logic auto_mode, // Autonomous conversion mode
  input logic conv_trigger, // Pulse: host conversion start
  input logic [2:0] chan_sel, // Manual channel
  input logic [7:0] sequence_channel_enable, // Autonomous channels
  output logic adc_start, // Pulse: start one conversion
  output logic [2:0] adc_chan, // Channel of that conversion
  input logic [11:0] adc_data, // Conversion code
  input logic adc_valid, // Pulse: adc_data valid
  output acc_pkg::acc_result_t result, // Last finished result
  output logic result_valid, // Pulse: result updated
  input logic crc_en, // CRC enable
  input logic alert_on_link_fault, // Alert on CRC error
  input logic halt_on_fault, // Stop autonomous mode on fault
  input logic [1:0] append_selection, // Appended field select
  input logic fault_clr, // Pulse: write 1 to fault flag
  output logic link_fault_flag, // CRC fault flag
  output logic alert, // Internal alert
  input logic [11:0] wc_high, // Window high threshold
  input logic [11:0] wc_low, // Window low threshold
  output logic wc_over, // Result above high threshold
  output logic wc_under, // Result below low threshold
  output logic [7:0] wr_data, // Accepted write byte
  output logic wr_valid // Pulse: wr_data accepted
);
  import acc_pkg::*;

  // =====================================================
  // Helpers
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = `ACC_CRC_SEED;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ b[i]) begin
        c = {c[6:0], 1'b0} ^ `ACC_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic logic [2:0] next_ch(input logic [2:0] c,
                                         input logic [7:0] m);
    logic [2:0] n;
    logic hit;
    n = c;
    hit = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      if (!hit && m[3'(c + 3'(i))]) begin
        n = 3'(c + 3'(i));
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // =====================================================
  // Link side, sclk domain
  // Host launches sdi on rising edges, device samples on falling
  // edges; sdo is launched on rising edges. cs_n high clears the
  // bit counters so every frame starts byte-aligned.
  logic lrst_n;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] rx_byte_reg;
  logic rx_tgl_reg;
  logic [4:0] tx_idx_reg;
  logic sdo_reg;
  logic sdo_oe_reg;
  logic [31:0] tx_word_reg;

  assign lrst_n = rst_n & ~cs_n;

  always_ff @(negedge sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      rx_cnt_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
    end else begin
      rx_cnt_reg <= rx_cnt_reg + 3'h1;
      rx_sh_reg <= {rx_sh_reg[6:0], sdi};
    end
  end

  // Byte hand-off: kept out of the frame reset so no false toggle
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte_reg <= 8'h00;
      rx_tgl_reg <= 1'b0;
    end else if (!cs_n && rx_cnt_reg == `ACC_RX_LAST) begin
      rx_byte_reg <= {rx_sh_reg[6:0], sdi};
      rx_tgl_reg <= ~rx_tgl_reg;
    end
  end

  // tx_word_reg only changes while the frame is idle, so it is
  // stable for the whole frame as seen from sclk
  always_ff @(posedge sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      tx_idx_reg <= 5'h00;
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_reg <= tx_word_reg[~tx_idx_reg];
      tx_idx_reg <= tx_idx_reg + 5'h01;
      sdo_oe_reg <= 1'b1;
    end
  end

  assign sdo = sdo_reg;
  assign sdo_oe = sdo_oe_reg;

  // =====================================================
  // Synchronisers into clk
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic tg_s1_reg;
  logic tg_s2_reg;
  logic tg_s3_reg;
  logic [7:0] gi_s1_reg;
  logic [7:0] gi_s2_reg;
  logic rx_evt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      tg_s3_reg <= 1'b0;
      gi_s1_reg <= 8'h00;
      gi_s2_reg <= 8'h00;
    end else if (ce) begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      tg_s1_reg <= rx_tgl_reg;
      tg_s2_reg <= tg_s1_reg;
      tg_s3_reg <= tg_s2_reg;
      gi_s1_reg <= gpio_in;
      gi_s2_reg <= gi_s1_reg;
    end
  end

  assign rx_evt = tg_s2_reg ^ tg_s3_reg;

  // =====================================================
  // Incoming bytes: CRC check, fault flag, write gating
  logic phase_reg;
  logic [7:0] stash_reg;
  logic fault_reg;
  logic alert_reg;
  logic [7:0] wr_data_reg;
  logic wr_valid_reg;
  logic unit_end;
  logic bad_evt;

  // With CRC on, bytes pair as data then CRC within a frame
  assign unit_end = rx_evt & (~crc_en | phase_reg);
  assign bad_evt = unit_end & crc_en &
                   (crc8(stash_reg) != rx_byte_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 1'b0;
      stash_reg <= 8'h00;
    end else if (ce) begin
      if (cs_s2_reg) begin
        phase_reg <= 1'b0;
      end else if (rx_evt && crc_en && !phase_reg) begin
        phase_reg <= 1'b1;
        stash_reg <= rx_byte_reg;
      end else if (rx_evt) begin
        phase_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg <= 1'b0;
    end else if (ce) begin
      if (bad_evt) begin
        fault_reg <= 1'b1;
      end else if (fault_clr) begin
        fault_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else if (ce) begin
      // Bad data and any write during a fault are dropped
      wr_valid_reg <= unit_end & ~bad_evt & ~fault_reg;
      if (unit_end) begin
        wr_data_reg <= crc_en ? stash_reg : rx_byte_reg;
      end
    end
  end

  assign link_fault_flag = fault_reg;
  assign wr_data = wr_data_reg;
  assign wr_valid = wr_valid_reg;

  // =====================================================
  // Channel functions and pin drive
  logic [7:0] gpio_out_reg;
  logic [7:0] gpio_oe_reg;
  logic [7:0] ana_reg;
  logic [7:0] rdbk_reg;
  logic [7:0] dig_out;

  assign dig_out = pin_cfg.func & pin_cfg.dir;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_reg <= `ACC_ALL_ANALOG;
      gpio_out_reg <= 8'h00;
      gpio_oe_reg <= 8'h00;
      rdbk_reg <= 8'h00;
    end else if (ce) begin
      ana_reg <= ~pin_cfg.func;
      gpio_out_reg <= pin_cfg.lvl & pin_cfg.drv;
      // Open-drain drives only the low level
      gpio_oe_reg <= dig_out & (pin_cfg.drv | ~pin_cfg.lvl);
      rdbk_reg <= gi_s2_reg & pin_cfg.func;
    end
  end

  assign gpio_out = gpio_out_reg;
  assign gpio_oe = gpio_oe_reg;
  assign analog_sel = ana_reg;
  assign pin_level_readback = rdbk_reg;

  // =====================================================
  // Offset calibration
  logic cal_reg;
  logic [15:0] cal_cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_reg <= 1'b0;
      cal_cnt_reg <= 16'h0000;
    end else if (ce) begin
      if (!cal_reg && cal_start) begin
        cal_reg <= 1'b1;
        cal_cnt_reg <= 16'(CAL_CYC - 1);
      end else if (cal_reg && cal_cnt_reg == 16'h0000) begin
        cal_reg <= 1'b0;
      end else if (cal_reg) begin
        cal_cnt_reg <= cal_cnt_reg - 16'h0001;
      end
    end
  end

  assign cal_busy = cal_reg;

  // =====================================================
  // Conversion sequencing and averaging
  acc_state_t state_reg;
  logic [2:0] ch_reg;
  logic [6:0] cnt_reg;
  logic [18:0] acc_reg;
  logic start_reg;
  logic [7:0] seq_mask;
  logic [6:0] last_cnt;
  logic [18:0] sum_nx;
  logic [22:0] scaled;
  logic avg_on;
  logic halted;
  logic go;
  logic done;

  // Only analog channels take part in the sequence
  assign seq_mask = sequence_channel_enable & ~pin_cfg.func;
  assign last_cnt = 7'((8'h01 << average_factor) - 8'h01);
  assign avg_on = |average_factor;
  assign halted = auto_mode & halt_on_fault & fault_reg;
  assign go = auto_mode ? (|seq_mask & ~halted) : conv_trigger;
  assign sum_nx = acc_reg + {7'h00, adc_data};
  assign done = state_reg == ACC_S_WAIT && adc_valid &&
                cnt_reg == last_cnt;
  assign scaled = {sum_nx, 4'h0} >> average_factor;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ACC_S_IDLE;
      ch_reg <= 3'h0;
      cnt_reg <= 7'h00;
      acc_reg <= 19'h00000;
      start_reg <= 1'b0;
    end else if (ce) begin
      start_reg <= 1'b0;
      case (state_reg)
        ACC_S_IDLE: begin
          if (go && !cal_reg) begin
            ch_reg <= auto_mode ? next_ch(ch_reg, seq_mask)
                                : chan_sel;
            start_reg <= 1'b1;
            cnt_reg <= 7'h00;
            acc_reg <= 19'h00000;
            state_reg <= ACC_S_WAIT;
          end
        end
        ACC_S_WAIT: begin
          if (adc_valid) begin
            acc_reg <= sum_nx;
            if (done) begin
              state_reg <= ACC_S_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 7'h01;
              start_reg <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ACC_S_IDLE;
        end
      endcase
    end
  end

  assign adc_start = start_reg;
  assign adc_chan = ch_reg;

  // =====================================================
  // Result, window compare, alert
  acc_result_t res_reg;
  logic res_valid_reg;
  logic over_reg;
  logic under_reg;
  logic [3:0] app;

  always_comb begin
    app = 4'h0;
    if (append_selection == `ACC_APP_STAT) begin
      app = {fault_reg, over_reg | under_reg, cal_reg, 1'b0};
    end else if (append_selection == `ACC_APP_CHID) begin
      app = {1'b0, ch_reg};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_reg <= '0;
      res_valid_reg <= 1'b0;
      over_reg <= 1'b0;
      under_reg <= 1'b0;
    end else if (ce) begin
      res_valid_reg <= done;
      if (done) begin
        res_reg.chan <= ch_reg;
        res_reg.data <= avg_on ? scaled[15:0]
                               : {sum_nx[11:0], app};
        over_reg <= scaled[15:`ACC_FRAC_BITS] > wc_high;
        under_reg <= scaled[15:`ACC_FRAC_BITS] < wc_low;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_reg <= 1'b0;
    end else if (ce) begin
      alert_reg <= alert_on_link_fault & fault_reg;
    end
  end

  assign result = res_reg;
  assign result_valid = res_valid_reg;
  assign wc_over = over_reg;
  assign wc_under = under_reg;
  assign alert = alert_reg;

  // =====================================================
  // Outgoing frame word, refreshed only while the frame is idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_word_reg <= 32'h00000000;
    end else if (ce && cs_s2_reg) begin
      if (crc_en) begin
        tx_word_reg <= {res_reg.data[15:8], crc8(res_reg.data[15:8]),
                        res_reg.data[7:0],
                        crc8(res_reg.data[7:0])};
      end else begin
        tx_word_reg <= {res_reg.data, 16'h0000};
      end
    end
  end

endmodule

// ==== acc_ctrl_assertions.sv ====
// Concurrent checks on the ports of the converter control block.
// Assumes binding into acc_ctrl; all checks run on clk.
`timescale 1ns/100ps
module acc_ctrl_chk import acc_pkg::*; #(
  parameter int CAL_CYC = 4
)(
  input logic clk, // Clock
  input logic rst_n, // Reset
  input logic cs_n, // Frame select
  input logic sdo_oe, // Out enable
  input acc_pkg::acc_pin_cfg_t pin_cfg, // Config
  input logic [7:0] analog_sel, // Analog
  input logic [7:0] gpio_oe, // Drive
  input logic [7:0] gpio_out, // Level
  input logic cal_start, // Cal start
  input logic cal_busy, // Cal bit
  input logic auto_mode, // Auto
  input logic [2:0] chan_sel, // Channel
  input logic [7:0] sequence_channel_enable, // Sequence
  input logic adc_start, // Start
  input logic [2:0] adc_chan, // Channel
  input logic adc_valid, // Sample
  input logic result_valid, // Result
  input logic crc_en, // CRC on
  input logic alert_on_link_fault, // Alert cfg
  input logic link_fault_flag, // Flag
  input logic alert, // Alert
  input logic wr_valid // Write
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // Length of the busy phase, counted so the repeat stays short
  int unsigned cal_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cal_cnt <= 0;
    else if (cal_busy) cal_cnt <= cal_cnt + 1;
    else cal_cnt <= 0;
  end
  // ==================================================
  // Properties
  // Outputs follow the configuration seen one edge earlier
  pin_func_a: assert property ($stable(pin_cfg) |=>
    analog_sel == ~$past(pin_cfg.func)) else $error("analog select wrong");
  pin_drive_a: assert property ($stable(pin_cfg) |=> gpio_oe ==
    ($past(pin_cfg.func) & $past(pin_cfg.dir) &
     ($past(pin_cfg.drv) | ~$past(pin_cfg.lvl))))
    else $error("drive enable wrong");
  out_level_a: assert property ($stable(pin_cfg) |=>
    (gpio_out & gpio_oe) == ($past(pin_cfg.lvl) & gpio_oe))
    else $error("output level wrong");
  cal_begin_a: assert property (cal_start && !cal_busy |=> cal_busy)
    else $error("calibration did not start");
  cal_length_a: assert property ($fell(cal_busy) |->
    cal_cnt == CAL_CYC) else $error("calibration length wrong");
  avg_next_a: assert property (adc_valid |=>
    adc_start || result_valid) else $error("sample not followed");
  seq_chan_a: assert property (adc_start |-> ($past(auto_mode) ?
    sequence_channel_enable[adc_chan] : adc_chan == chan_sel))
    else $error("conversion channel wrong");
  fault_en_a: assert property ($rose(link_fault_flag) |-> crc_en)
    else $error("fault without CRC");
  write_block_a: assert property (wr_valid |-> !link_fault_flag)
    else $error("write while fault");
  alert_fault_a: assert property (alert ==
    $past(alert_on_link_fault && link_fault_flag)) else $error("alert wrong");
  sdo_idle_a: assert property (cs_n |-> !sdo_oe)
    else $error("sdo driven outside frame");
endmodule

bind acc_ctrl acc_ctrl_chk #(.CAL_CYC(CAL_CYC)) chk_inst (.*);

// ==== acc_host_model.sv ====
// Serial host model: frames of up to 32 bits and a CRC-8 helper.
// Assumes the device takes sdi on sclk fall and launches sdo on rise.
`timescale 1ns/100ps
module acc_host_model (
  output logic sclk, // Link clock
  output logic cs_n, // Frame select
  output logic sdi, // Data to device
  input logic sdo, // Data from device
  input logic sdo_oe // Device drives sdo
);
  // ==================================================
  // CRC-8 over one byte, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // ==================================================
  // Odd start offset keeps link edges off the clk edges
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = 32'h0;
    #1.3;
    cs_n = 1'b0;
    #32;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      sdi = tx[31-i];
      #32;
      sclk = 1'b0;
      rx = {rx[30:0], sdo_oe ? sdo : 1'bx};
      #32;
    end
    cs_n = 1'b1;
    sdi = ~sdi; // Released line must not keep its last bit
    #100;
  endtask
endmodule

// ==== acc_ctrl_tb.sv ====
// Self-checking bench for acc_ctrl with a host model and converter stub.
// Assumes acc_pkg, the checker and acc_host_model are compiled first.
`timescale 1ns/100ps
module acc_ctrl_tb;
  import acc_pkg::*;
  localparam int CAL = 4;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe;
  acc_pin_cfg_t pin_cfg = '0;
  logic [7:0] ext = 8'h00, gpio_in, gpio_out, gpio_oe, analog_sel;
  logic [7:0] pin_level_readback, sequence_channel_enable = 8'h00;
  logic cal_start = 1'b0, cal_busy, auto_mode = 1'b0, conv_trigger = 1'b0;
  logic [2:0] average_factor = 3'h0, chan_sel = 3'h0, adc_chan, dly = 3'h0;
  logic adc_start, adc_valid = 1'b0, result_valid, wr_valid, wc_over;
  logic [11:0] adc_data = 12'h000, wc_high = 12'hfff, wc_low = 12'h000;
  acc_result_t result;
  logic crc_en = 1'b0, alert_on_link_fault = 1'b0, halt_on_fault = 1'b0;
  logic [1:0] append_selection = 2'b00;
  logic fault_clr = 1'b0, link_fault_flag, alert, wc_under;
  logic [7:0] wr_data;
  logic [31:0] sum, rx;
  logic [15:0] last_d;
  logic [2:0] chq [$];
  logic [7:0] wq [$];
  int n_mismatch = 0, tests_run = 0, n_start = 0;
  always #5 clk = ~clk;
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext);
  acc_ctrl #(.CAL_CYC(CAL)) acc_ctrl_inst (.*);
  acc_host_model host_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));
  // ==================================================
  // Converter stub: answers each start three cycles later
  always @(negedge clk) begin
    if (adc_start) n_start++;
    if (adc_start) chq.push_back(adc_chan);
    if (adc_valid) sum += adc_data;
    if (adc_valid) adc_data += 12'h001;
    if (wr_valid) wq.push_back(wr_data);
    adc_valid = dly[2];
    dly = {dly[1:0], adc_start};
  end
  // ==================================================
  // Shared tasks
  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // ==================================================
  // Scenarios
  task automatic t_gpio(input logic [31:0] c, input logic [7:0] e);
    logic [7:0] oe, an;
    pin_cfg = c;
    ext = e;
    an = ~c[31:24];
    oe = c[31:24] & c[23:16] & (c[15:8] | ~c[7:0]);
    repeat (6) @(negedge clk);
    chk(analog_sel, an);
    chk(gpio_oe, oe);
    chk(gpio_out & oe, c[7:0] & oe);
    chk(pin_level_readback, c[31:24] & ((oe & c[7:0]) | (~oe & e)));
  endtask
  task automatic t_cal();
    int n;
    n_start = 0;
    cal_start = 1'b1;
    @(negedge clk);
    cal_start = 1'b0;
    conv_trigger = 1'b1;
    for (n = 0; n < 50 && cal_busy === 1'b1; n++) @(negedge clk);
    conv_trigger = 1'b0;
    repeat (8) @(negedge clk);
    chk(n, CAL);
    chk(n_start, 0);
  endtask
  task automatic t_conv(input logic [2:0] f, input logic [2:0] ch,
                        input logic [1:0] ap, input logic [3:0] e4);
    int i;
    logic [31:0] ex;
    average_factor = f;
    chan_sel = ch;
    append_selection = ap;
    sum = 0;
    n_start = 0;
    conv_trigger = 1'b1;
    @(negedge clk);
    conv_trigger = 1'b0;
    for (i = 0; i < 3000 && result_valid !== 1'b1; i++) @(negedge clk);
    if (i == 3000) begin
      n_mismatch++;
      finish_test();
    end
    #1;
    ex = (f == 3'h0) ? {sum[11:0], e4} : (sum << 4) >> f;
    last_d = ex[15:0];
    chk(result.data, ex);
    chk(result.chan, ch);
    chk(n_start, 1 << f);
    repeat (4) @(negedge clk);
  endtask
  task automatic t_link();
    crc_en = 1'b1;
    alert_on_link_fault = 1'b1;
    halt_on_fault = 1'b1;
    host_inst.xfer({8'h3c, host_inst.crc8(8'h3c), 8'hc3,
      host_inst.crc8(8'hc3)}, 32, rx);
    repeat (10) @(negedge clk);
    chk(wq.size(), 2);
    chk({wq[0], wq[1]}, 16'h3cc3);
    chk(rx, {last_d[15:8], host_inst.crc8(last_d[15:8]), last_d[7:0],
      host_inst.crc8(last_d[7:0])});
    host_inst.xfer({8'h11, ~host_inst.crc8(8'h11), 16'h0}, 16, rx);
    repeat (10) @(negedge clk);
    chk({link_fault_flag, alert}, 2'b11);
    host_inst.xfer({8'h22, host_inst.crc8(8'h22), 16'h0}, 16, rx);
    repeat (10) @(negedge clk);
    chk(wq.size(), 2);
    n_start = 0;
    sequence_channel_enable = 8'h24;
    auto_mode = 1'b1;
    repeat (50) @(negedge clk);
    auto_mode = 1'b0;
    chk(n_start, 0);
    t_conv(3'h0, 3'h1, 2'b10, 4'h8);
    fault_clr = 1'b1;
    @(negedge clk);
    fault_clr = 1'b0;
    repeat (3) @(negedge clk);
    chk({link_fault_flag, alert}, 2'b00);
    host_inst.xfer({8'h22, host_inst.crc8(8'h22), 16'h0}, 16, rx);
    repeat (10) @(negedge clk);
    chk(wq[2], 8'h22);
    crc_en = 1'b0;
    host_inst.xfer({8'h55, 8'h00, 16'h0}, 16, rx);
    repeat (10) @(negedge clk);
    chk({wq.size(), link_fault_flag}, {32'd5, 1'b0});
    chk(rx[15:0], last_d);
  endtask
  task automatic t_auto();
    int i;
    average_factor = 3'h0;
    chq.delete();
    auto_mode = 1'b1;
    for (i = 0; i < 500 && chq.size() < 4; i++) @(negedge clk);
    auto_mode = 1'b0;
    chk({chq[0] ^ chq[1], chq[1] ^ chq[2], chq[2] ^ chq[3]}, 9'h1ff);
    repeat (20) @(negedge clk);
  endtask
  // ==================================================
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk({analog_sel, gpio_oe, link_fault_flag}, 17'h1fe00);
    t_gpio(32'hf0cc_aa96, 8'h5a);
    t_gpio(32'hff0f_3355, 8'ha5);
    pin_cfg = '0;
    t_cal();
    adc_data = 12'hfff;
    t_conv(3'h0, 3'h5, 2'b01, 4'h5);
    t_conv(3'h0, 3'h2, 2'b10, 4'h0);
    for (int f = 1; f < 8; f++) begin
      adc_data = 12'hff8;
      t_conv(3'(f), 3'(f), 2'b00, 4'h0);
    end
    t_link();
    // Average of 900 and 901 has top bits 900, above an 800 limit
    wc_high = 12'h800;
    adc_data = 12'h900;
    t_conv(3'h1, 3'h3, 2'b00, 4'h0);
    chk({wc_over, wc_under}, 2'b10);
    wc_high = 12'hfff;
    t_auto();
    finish_test();
  end
endmodule
